// ### rtl/ais_pkg.sv
// Constants and route types for the converter input selector
package ais_pkg;
	localparam int SFR_W = 8;
	localparam int CODE_W = 5;
	localparam int OFFSET_W = 10;
	localparam logic [7:0] PAGE_MAIN = 8'h00;
	localparam logic [7:0] PAGE_CAL = 8'h0f;
	localparam logic [7:0] ADDR_INPUT_SELECT = 8'h96;
	localparam logic [7:0] ADDR_OFFSET_HIGH = 8'h8e;
	localparam logic [7:0] ADDR_OFFSET_LOW = 8'h8d;
	localparam logic [7:0] ADDR_REF_CTRL = 8'hd1;
	localparam int TEMP_EN_POS = 2;
	localparam int OFFSET_LOW_POS = 6;
	localparam logic [4:0] INPUT_SELECT_RESET = 5'h1f;
	localparam logic TEMP_EN_RESET = 1'b0;
	localparam logic [9:0] OFFSET_RESET = 10'h000;
	localparam logic [7:0] RDATA_RESET = 8'h00;
	localparam logic [4:0] CODE_P0_FIRST = 5'h01;
	localparam logic [4:0] CODE_P0_LAST = 5'h07;
	localparam logic [4:0] CODE_P1_FIRST = 5'h0a;
	localparam logic [4:0] CODE_P1_LAST = 5'h0c;
	localparam logic [4:0] CODE_P1_PIN4 = 5'h0c;
	localparam logic [4:0] CODE_TEMP = 5'h1b;
	localparam logic [4:0] CODE_VDD_A = 5'h1c;
	localparam logic [4:0] CODE_VCORE = 5'h1d;
	localparam logic [4:0] CODE_VDD_B = 5'h1e;
	localparam logic [4:0] CODE_GND = 5'h1f;

	typedef enum logic [2:0] {
		RT_NONE, RT_PORT0, RT_PORT1, RT_TEMP, RT_VDD, RT_VCORE, RT_GND
	} ais_route_t;

	// Route class of a code; pin 4 of port 1 only exists on large package
	function automatic ais_route_t ais_route_of(input logic [4:0] code,
			input logic pkg24);
		ais_route_t r;
		r = RT_NONE;
		if (code >= CODE_P0_FIRST && code <= CODE_P0_LAST) begin
			r = RT_PORT0;
		end else if (code >= CODE_P1_FIRST && code <= CODE_P1_LAST) begin
			r = (code == CODE_P1_PIN4 && !pkg24) ? RT_NONE : RT_PORT1;
		end else if (code == CODE_TEMP) begin
			r = RT_TEMP;
		end else if (code == CODE_VDD_A || code == CODE_VDD_B) begin
			r = RT_VDD;
		end else if (code == CODE_VCORE) begin
			r = RT_VCORE;
		end else if (code == CODE_GND) begin
			r = RT_GND;
		end
		return r;
	endfunction
endpackage

// ### rtl/ais_route_if.sv
// Selection code and decoded analog routes between top and decoder
`timescale 1ns/1ps
interface ais_route_if;
	logic [4:0] code;
	logic pkg24;
	logic [6:0] port0;
	logic [2:0] port1;
	logic temp;
	logic vdd;
	logic vcore;
	logic gnd;
	logic reserved;
	modport dec (input code, pkg24,
		output port0, port1, temp, vdd, vcore, gnd, reserved);
	modport user (output code, pkg24,
		input port0, port1, temp, vdd, vcore, gnd, reserved);
endinterface

// ### rtl/ais_decode.sv
// Combinational decode of the positive-input code into switch enables
`timescale 1ns/1ps
module ais_decode
	import ais_pkg::*;
(
	ais_route_if.dec rt
);
	ais_route_t route;
	logic [4:0] p0_idx;
	logic [4:0] p1_idx;

	always_comb begin
		route = ais_route_of(rt.code, rt.pkg24);
		p0_idx = rt.code - CODE_P0_FIRST;
		p1_idx = rt.code - CODE_P1_FIRST;
		rt.port0 = 7'h00;
		rt.port1 = 3'h0;
		rt.temp = 1'b0;
		rt.vdd = 1'b0;
		rt.vcore = 1'b0;
		rt.gnd = 1'b0;
		rt.reserved = 1'b0;
		case (route)
			RT_PORT0: rt.port0 = 7'h01 << p0_idx[2:0];
			RT_PORT1: rt.port1 = 3'h1 << p1_idx[1:0];
			RT_TEMP: rt.temp = 1'b1;
			RT_VDD: rt.vdd = 1'b1;
			RT_VCORE: rt.vcore = 1'b1;
			RT_GND: rt.gnd = 1'b1;
			// No switch closed on reserved codes
			default: rt.reserved = 1'b1;
		endcase
	end
endmodule

// ### rtl/ais_top.sv
// Input selector and factory offset registers on the SFR bus
`timescale 1ns/1ps
module ais_top #(
	parameter bit PKG_24_PIN = 1'b1
) (
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic ARST_N,
	// SFR bus
	input wire logic [7:0] SFR_PAGE,
	input wire logic [7:0] SFR_ADDR,
	input wire logic SFR_WR,
	input wire logic SFR_RD,
	input wire logic [ais_pkg::SFR_W-1:0] SFR_WDATA,
	output logic [ais_pkg::SFR_W-1:0] SFR_RDATA,
	output logic SFR_RD_HIT,
	// Factory trim word
	input wire logic [ais_pkg::OFFSET_W-1:0] FACTORY_TEMP_OFFSET,
	// Analog switch controls
	output logic [6:0] ROUTE_PORT0,
	output logic [2:0] ROUTE_PORT1,
	output logic ROUTE_TEMP,
	output logic ROUTE_VDD,
	output logic ROUTE_VCORE,
	output logic ROUTE_GND,
	output logic CODE_RESERVED,
	// Temperature sensor
	output logic TEMP_SENSOR_EN,
	output logic TEMP_SENSOR_HIZ,
	output logic TEMP_READING_VALID
);
	import ais_pkg::*;

	if (PKG_24_PIN !== 1'b0 && PKG_24_PIN !== 1'b1) begin : g_bad_pkg
		$error("PKG_24_PIN must be 0 or 1");
	end

	ais_route_if rt ();

	logic [4:0] code_r, code_nxt;
	logic temp_en_r, temp_en_nxt;
	logic [9:0] offset_r, offset_nxt;
	logic loaded_r, loaded_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic hit_r, hit_nxt;
	logic hiz_r, hiz_nxt;
	logic valid_r, valid_nxt;
	logic [6:0] p0_r;
	logic [2:0] p1_r;
	logic temp_r, vdd_r, vcore_r, gnd_r, resv_r;
	logic wr_sel, wr_ref, on_main, on_cal;

	assign rt.code = code_r;
	assign rt.pkg24 = PKG_24_PIN;

	ais_decode u_decode (
		.rt(rt)
	);

	always_comb begin
		on_main = (SFR_PAGE == PAGE_MAIN);
		on_cal = (SFR_PAGE == PAGE_CAL);
		wr_sel = SFR_WR && on_main && SFR_ADDR == ADDR_INPUT_SELECT;
		wr_ref = SFR_WR && on_main && SFR_ADDR == ADDR_REF_CTRL;
		code_nxt = code_r;
		temp_en_nxt = temp_en_r;
		if (wr_sel) begin
			code_nxt = SFR_WDATA[4:0];
		end
		if (wr_ref) begin
			temp_en_nxt = SFR_WDATA[TEMP_EN_POS];
		end
		// Registered so these outputs match the enable and route timing
		hiz_nxt = !temp_en_nxt;
		valid_nxt = rt.temp && temp_en_nxt;
		// trim caught after reset release
		// Caught once so a floating trim input cannot drift the value
		offset_nxt = loaded_r ? offset_r : FACTORY_TEMP_OFFSET;
		loaded_nxt = 1'b1;
		// Offset registers ignore writes; read data holds between reads
		rdata_nxt = rdata_r;
		hit_nxt = 1'b0;
		if (SFR_RD) begin
			rdata_nxt = 8'h00;
			if (on_main && SFR_ADDR == ADDR_INPUT_SELECT) begin
				rdata_nxt = {3'h0, code_r};
				hit_nxt = 1'b1;
			end else if (on_main && SFR_ADDR == ADDR_REF_CTRL) begin
				rdata_nxt[TEMP_EN_POS] = temp_en_r;
				hit_nxt = 1'b1;
			end else if (on_cal && SFR_ADDR == ADDR_OFFSET_HIGH) begin
				rdata_nxt = offset_r[9:2];
				hit_nxt = 1'b1;
			end else if (on_cal && SFR_ADDR == ADDR_OFFSET_LOW) begin
				rdata_nxt = {offset_r[1:0], 6'h00};
				hit_nxt = 1'b1;
			end
		end
	end

	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			code_r <= INPUT_SELECT_RESET;
			temp_en_r <= TEMP_EN_RESET;
			offset_r <= OFFSET_RESET;
			loaded_r <= 1'b0;
			rdata_r <= RDATA_RESET;
			hit_r <= 1'b0;
			hiz_r <= 1'b1;
			valid_r <= 1'b0;
		end else begin
			code_r <= code_nxt;
			temp_en_r <= temp_en_nxt;
			offset_r <= offset_nxt;
			loaded_r <= loaded_nxt;
			rdata_r <= rdata_nxt;
			hit_r <= hit_nxt;
			hiz_r <= hiz_nxt;
			valid_r <= valid_nxt;
		end
	end

	// Switch enables registered; one cycle behind the select register
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			p0_r <= 7'h00;
			p1_r <= 3'h0;
			temp_r <= 1'b0;
			vdd_r <= 1'b0;
			vcore_r <= 1'b0;
			gnd_r <= 1'b0;
			resv_r <= 1'b0;
		end else begin
			p0_r <= rt.port0;
			p1_r <= rt.port1;
			temp_r <= rt.temp;
			vdd_r <= rt.vdd;
			vcore_r <= rt.vcore;
			gnd_r <= rt.gnd;
			resv_r <= rt.reserved;
		end
	end

	assign SFR_RDATA = rdata_r;
	assign SFR_RD_HIT = hit_r;
	assign ROUTE_PORT0 = p0_r;
	assign ROUTE_PORT1 = p1_r;
	assign ROUTE_TEMP = temp_r;
	assign ROUTE_VDD = vdd_r;
	assign ROUTE_VCORE = vcore_r;
	assign ROUTE_GND = gnd_r;
	assign CODE_RESERVED = resv_r;
	assign TEMP_SENSOR_EN = temp_en_r;
	assign TEMP_SENSOR_HIZ = hiz_r;
	// Only a reading with sensor powered means anything
	assign TEMP_READING_VALID = valid_r;

	a_select_write: assert property (
		@(posedge CLK_SYS) disable iff (!ARST_N)
		SFR_WR && SFR_PAGE == PAGE_MAIN && SFR_ADDR == ADDR_INPUT_SELECT
		##1 (SFR_RD && SFR_PAGE == PAGE_MAIN &&
		SFR_ADDR == ADDR_INPUT_SELECT && !SFR_WR) |=>
		SFR_RDATA[4:0] == $past(SFR_WDATA[4:0], 2))
		else $error("select write not read back");
	a_ground_route: assert property (
		@(posedge CLK_SYS) disable iff (!ARST_N)
		code_r == CODE_GND |=> ROUTE_GND && ROUTE_PORT0 == 7'h00 &&
		!CODE_RESERVED)
		else $error("ground code not routed");
	a_small_package: assert property (
		@(posedge CLK_SYS) disable iff (!ARST_N)
		code_r == CODE_P1_PIN4
		|=> ROUTE_PORT1 == (PKG_24_PIN ? 3'h4 : 3'h0) &&
		CODE_RESERVED == !PKG_24_PIN)
		else $error("missing pin routed");
	a_core_supply: assert property (
		@(posedge CLK_SYS) disable iff (!ARST_N)
		code_r == CODE_VCORE |=> ROUTE_VCORE && !ROUTE_VDD)
		else $error("core supply not routed");
	a_temp_route: assert property (
		@(posedge CLK_SYS) disable iff (!ARST_N)
		$rose(code_r == CODE_TEMP) |=> $rose(ROUTE_TEMP) && !ROUTE_GND)
		else $error("sensor not routed");
	a_sensor_float: assert property (
		@(posedge CLK_SYS) disable iff (!ARST_N)
		!TEMP_SENSOR_EN |-> TEMP_SENSOR_HIZ && !TEMP_READING_VALID)
		else $error("disabled sensor not floating");
	a_offset_held: assert property (
		@(posedge CLK_SYS) disable iff (!ARST_N)
		loaded_r |=> $stable(offset_r))
		else $error("offset changed after capture");
	a_offset_high: assert property (
		@(posedge CLK_SYS) disable iff (!ARST_N)
		SFR_RD && SFR_PAGE == PAGE_CAL && SFR_ADDR == ADDR_OFFSET_HIGH
		|=> SFR_RD_HIT && SFR_RDATA == $past(offset_r[9:2]))
		else $error("offset high read wrong");
	a_offset_low: assert property (
		@(posedge CLK_SYS) disable iff (!ARST_N)
		SFR_RD && SFR_PAGE == PAGE_CAL && SFR_ADDR == ADDR_OFFSET_LOW
		|=> SFR_RDATA[7:6] == $past(offset_r[1:0]))
		else $error("offset low read wrong");
	a_low_zero: assert property (
		@(posedge CLK_SYS) disable iff (!ARST_N)
		SFR_RD && SFR_PAGE == PAGE_CAL && SFR_ADDR == ADDR_OFFSET_LOW
		|=> SFR_RDATA[5:0] == 6'h00)
		else $error("offset low unused bits set");
	a_page_gate: assert property (
		@(posedge CLK_SYS) disable iff (!ARST_N)
		SFR_RD && SFR_PAGE != PAGE_CAL && (SFR_ADDR == ADDR_OFFSET_HIGH
		|| SFR_ADDR == ADDR_OFFSET_LOW) |=> !SFR_RD_HIT &&
		SFR_RDATA == 8'h00)
		else $error("offset visible off its page");
	a_enable_bit: assert property (
		@(posedge CLK_SYS) disable iff (!ARST_N)
		SFR_WR && SFR_PAGE == PAGE_MAIN && SFR_ADDR == ADDR_REF_CTRL
		|=> TEMP_SENSOR_EN == $past(SFR_WDATA[TEMP_EN_POS]))
		else $error("sensor enable not written");
	a_upper_zero: assert property (
		@(posedge CLK_SYS) disable iff (!ARST_N)
		SFR_RD && SFR_PAGE == PAGE_MAIN && SFR_ADDR == ADDR_INPUT_SELECT
		|=> SFR_RDATA[7:5] == 3'h0)
		else $error("select upper bits set");
endmodule

// ### verification/ais_testbench.sv
// Self-checking bench for the input selector and offset registers
`timescale 1ns/1ps
module testbench;
	import ais_pkg::*;
	logic CLK_SYS, ARST_N, SFR_WR, SFR_RD, SFR_RD_HIT;
	logic [7:0] SFR_PAGE, SFR_ADDR, SFR_WDATA, SFR_RDATA;
	logic [9:0] FACTORY_TEMP_OFFSET;
	logic [6:0] ROUTE_PORT0;
	logic [2:0] ROUTE_PORT1;
	logic ROUTE_TEMP, ROUTE_VDD, ROUTE_VCORE, ROUTE_GND, CODE_RESERVED;
	logic TEMP_SENSOR_EN, TEMP_SENSOR_HIZ, TEMP_READING_VALID;
	int miscompares = 0;
	int comparisons = 0;
	int cycles = 0;
	logic [8:0] rd_q[$];
	logic [17:0] rt_q[$];
	logic [8:0] rd_e;
	logic rd_d = 1'b0;
	logic rt_chk = 1'b0;
	logic [4:0] sel_sh;
	logic en_sh;
	logic [7:0] rnd;

	// 24-pin part, so code 0c is legal stimulus
	ais_top #(.PKG_24_PIN(1'b1)) DUT (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N),
		.SFR_PAGE(SFR_PAGE), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR),
		.SFR_RD(SFR_RD), .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA),
		.SFR_RD_HIT(SFR_RD_HIT), .FACTORY_TEMP_OFFSET(FACTORY_TEMP_OFFSET),
		.ROUTE_PORT0(ROUTE_PORT0), .ROUTE_PORT1(ROUTE_PORT1),
		.ROUTE_TEMP(ROUTE_TEMP), .ROUTE_VDD(ROUTE_VDD),
		.ROUTE_VCORE(ROUTE_VCORE), .ROUTE_GND(ROUTE_GND),
		.CODE_RESERVED(CODE_RESERVED), .TEMP_SENSOR_EN(TEMP_SENSOR_EN),
		.TEMP_SENSOR_HIZ(TEMP_SENSOR_HIZ),
		.TEMP_READING_VALID(TEMP_READING_VALID));

	initial begin
		CLK_SYS = 1'b0;
		forever #5 CLK_SYS = ~CLK_SYS;
	end

	task automatic check(input string name, input logic [17:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic report_and_stop;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	function automatic logic [17:0] exp_route(logic [4:0] c, logic en);
		logic [6:0] p0;
		logic [2:0] p1;
		logic t, v, vc, g;
		p0 = (c >= 5'h01 && c <= 5'h07) ? 7'h01 << (c - 5'h01) : 7'h00;
		p1 = (c >= 5'h0a && c <= 5'h0c) ? 3'h1 << (c - 5'h0a) : 3'h0;
		t = (c == 5'h1b);
		v = (c == 5'h1c || c == 5'h1e);
		vc = (c == 5'h1d);
		g = (c == 5'h1f);
		return {p0, p1, t, v, vc, g, ~|{p0, p1, t, v, vc, g}, en, ~en, t & en};
	endfunction

	function automatic logic [8:0] exp_rd(logic [7:0] pg, ad);
		case ({pg, ad})
			16'h0096: return {1'b1, 3'h0, sel_sh};
			16'h00d1: return {1'b1, 5'h00, en_sh, 2'h0};
			16'h0f8e: return {1'b1, FACTORY_TEMP_OFFSET[9:2]};
			16'h0f8d: return {1'b1, FACTORY_TEMP_OFFSET[1:0], 6'h00};
			default: return 9'h000;
		endcase
	endfunction

	// Read notes are taken before the write lands: same-cycle read sees old
	task automatic op(input logic wr, rd, input logic [7:0] pg, ad, wd);
		@(posedge CLK_SYS);
		SFR_WR <= wr;
		SFR_RD <= rd;
		SFR_PAGE <= pg;
		SFR_ADDR <= ad;
		SFR_WDATA <= wd;
		if (rd) rd_q.push_back(exp_rd(pg, ad));
		if (wr && pg == 8'h00 && ad == 8'h96) sel_sh = wd[4:0];
		if (wr && pg == 8'h00 && ad == 8'hd1) en_sh = wd[2];
	endtask

	task automatic route_check;
		op(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
		@(posedge CLK_SYS);
		rt_chk <= 1'b1;
		rt_q.push_back(exp_route(sel_sh, en_sh));
		@(posedge CLK_SYS);
		rt_chk <= 1'b0;
	endtask

	always @(posedge CLK_SYS) begin
		cycles++;
		if (rd_d) begin
			rd_e = rd_q.pop_front();
			check("read data", {10'h0, SFR_RDATA}, {10'h0, rd_e[7:0]});
			check("read hit", {17'h0, SFR_RD_HIT}, {17'h0, rd_e[8]});
		end
		if (rt_chk) begin
			check("routes", {ROUTE_PORT0, ROUTE_PORT1, ROUTE_TEMP, ROUTE_VDD,
				ROUTE_VCORE, ROUTE_GND, CODE_RESERVED, TEMP_SENSOR_EN,
				TEMP_SENSOR_HIZ, TEMP_READING_VALID}, rt_q.pop_front());
		end
		rd_d <= SFR_RD;
		// Run is under a thousand cycles; a hang ends here
		if (cycles > 3000) begin
			miscompares++;
			report_and_stop();
		end
	end

	initial begin
		void'($urandom(67037));
		ARST_N = 1'b0;
		SFR_WR = 1'b0;
		SFR_RD = 1'b0;
		SFR_PAGE = 8'h00;
		SFR_ADDR = 8'h00;
		SFR_WDATA = 8'h00;
		FACTORY_TEMP_OFFSET = 10'($urandom);
		sel_sh = 5'h1f;
		en_sh = 1'b0;
		repeat (4) @(posedge CLK_SYS);
		ARST_N <= 1'b1;
		repeat (2) @(posedge CLK_SYS);
		op(1'b0, 1'b1, 8'h00, 8'h96, 8'h00);
		op(1'b0, 1'b1, 8'h00, 8'hd1, 8'h00);
		route_check();
		for (int i = 0; i < 2; i++) begin
			op(1'b0, 1'b1, 8'h0f, 8'h8e, 8'h00);
			op(1'b0, 1'b1, 8'h0f, 8'h8d, 8'h00);
			op(1'b1, 1'b0, 8'h0f, 8'h8e, 8'hff);
			op(1'b1, 1'b0, 8'h0f, 8'h8d, 8'hff);
		end
		op(1'b0, 1'b1, 8'h00, 8'h8e, 8'h00);
		op(1'b0, 1'b1, 8'h0f, 8'h96, 8'h00);
		op(1'b0, 1'b1, 8'h0f, 8'hd1, 8'h00);
		op(1'b0, 1'b1, 8'h00, 8'h55, 8'h00);
		op(1'b1, 1'b0, 8'h0f, 8'h96, 8'h0b);
		op(1'b0, 1'b1, 8'h00, 8'h96, 8'h00);
		// every code, sensor off then on
		for (int e = 0; e < 2; e++) begin
			for (int c = 0; c < 32; c++) begin
				rnd = 8'($urandom);
				op(1'b1, 1'b0, 8'h00, 8'hd1, (rnd & 8'hfb) | 8'(e << 2));
				op(1'b1, 1'b0, 8'h00, 8'h96, {rnd[7:5], 5'(c)});
				op(1'b0, 1'b1, 8'h00, 8'h96, 8'h00);
				op(1'b0, 1'b1, 8'h00, 8'hd1, 8'h00);
				route_check();
			end
		end
		// Read and write together: read returns the old code
		op(1'b1, 1'b1, 8'h00, 8'h96, 8'h05);
		op(1'b0, 1'b1, 8'h00, 8'h96, 8'h00);
		route_check();
		repeat (3) @(posedge CLK_SYS);
		report_and_stop();
	end
endmodule
